// ---- rtl/epb_consts.vh ----
/*
  constants for the endpoint buffer state tracker: register offsets,
  field positions, state codes and the configuration register layout.
  assumes inclusion by bare name from the design files.
*/
`ifndef EPB_CONSTS_VH
`define EPB_CONSTS_VH

// register byte offsets on the apb bus
`define EPB_ADDR_STATES 12'h02C
`define EPB_ADDR_CFG 12'h030
`define EPB_ADDR_W 12

// buffer state codes
`define EPB_ST_FREE 2'h0
`define EPB_ST_VALID 2'h1
`define EPB_ST_LCL 2'h2
`define EPB_ST_USB 2'h3

// state report field positions
`define EPB_FLD_A_LO 0
`define EPB_FLD_B_LO 2

// configuration register fields
`define EPB_CFG_DIR_BIT 0
`define EPB_CFG_DBL_BIT 1
`define EPB_CFG_RESET 2'h0

`endif

// ---- rtl/epb_buffer_slot.v ----
/*
  one packet buffer slot: holds its two-bit ownership state and walks it
  one step at a time in the order that the transfer direction sets.
  assumes the parent gates each step request and resolves the pair.
*/
`timescale 1ns/10ps
`default_nettype none
`include "epb_consts.vh"

module epb_buffer_slot (
  // clock and reset
  input wire CLK_SYS,
  input wire NRST,
  input wire CE,
  // control
  input wire dir_in,
  input wire clear,
  input wire step,
  // state
  output reg [1:0] state
);

  // next state of the slot
  reg [1:0] next_state;

  // successor of a state for the given direction
  function [1:0] epb_succ;
    input [1:0] cur;
    input in_dir;
    begin
      case (cur)
        `EPB_ST_FREE: epb_succ = in_dir ? `EPB_ST_LCL : `EPB_ST_USB;
        `EPB_ST_LCL: epb_succ = in_dir ? `EPB_ST_VALID : `EPB_ST_FREE;
        `EPB_ST_VALID: epb_succ = in_dir ? `EPB_ST_USB : `EPB_ST_LCL;
        `EPB_ST_USB: epb_succ = in_dir ? `EPB_ST_FREE : `EPB_ST_VALID;
        default: epb_succ = `EPB_ST_FREE;
      endcase
    end
  endfunction

  // step chooser
  always @* begin
    next_state = state;
    if (clear) begin
      next_state = `EPB_ST_FREE;
    end else if (step) begin
      next_state = epb_succ(state, dir_in);
    end
  end

  // state register
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= `EPB_ST_FREE;
    end else if (CE) begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/epb_endpoint_buffers.v ----
/*
  endpoint ping-pong buffer ownership tracker with an apb slave.
  slot a, and in double buffered mode slot b, each move through free, local, valid and bus-owned
  states; the protocol engine and local side pulse events that move the
  slot that is next in line. software reads both states in one register.
  assumes apb signals and event pulses are synchronous to CLK_SYS.
*/
`timescale 1ns/10ps
`default_nettype none
`include "epb_consts.vh"

// Behaviour
// - in endpoint: local, valid, bus, free
// - out endpoint: bus, valid, local, free
// - double buffered slots share no state but free
// - single buffered: slot b stays free
// - bus-owned slot reads code 11
// - free 00, valid 01, local 10
// - a bits 1:0, b 3:2, rest zero
module epb_endpoint_buffers (
  // clock, reset, enable
  input wire CLK_SYS,
  input wire NRST,
  input wire CE,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // buffer events, one-cycle pulses
  input wire EV_CLAIM,
  input wire EV_RELEASE,
  // buffer status
  output reg [7:0] STATE_REPORT
);

  // configuration: direction and double buffering
  reg [1:0] cfg;
  // which slot the next step tries first
  reg turn;
  // reconfiguration clears both slots
  reg clear;
  // per-slot step requests
  reg step_a;
  reg step_b;
  // apb access phase strobes
  wire acc = PSEL & PENABLE & ~PREADY;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  // slot states
  wire [1:0] st_a;
  wire [1:0] st_b;
  wire dir_in = cfg[`EPB_CFG_DIR_BIT];
  wire dbl = cfg[`EPB_CFG_DBL_BIT];
  // report word
  wire [7:0] report;

  // true when a state is one a given event may leave
  function epb_movable;
    input [1:0] cur;
    input in_dir;
    input claim;
    begin
      // claim moves free or valid slots, release moves owned slots
      if (claim) begin
        epb_movable = (cur == `EPB_ST_FREE) || (cur == `EPB_ST_VALID);
      end else begin
        epb_movable = (cur == `EPB_ST_LCL) || (cur == `EPB_ST_USB);
      end
    end
  endfunction

  // slot successor, to check the partner does not already hold it
  function [1:0] epb_next;
    input [1:0] cur;
    input in_dir;
    begin
      case (cur)
        `EPB_ST_FREE: epb_next = in_dir ? `EPB_ST_LCL : `EPB_ST_USB;
        `EPB_ST_LCL: epb_next = in_dir ? `EPB_ST_VALID : `EPB_ST_FREE;
        `EPB_ST_VALID: epb_next = in_dir ? `EPB_ST_USB : `EPB_ST_LCL;
        `EPB_ST_USB: epb_next = in_dir ? `EPB_ST_FREE : `EPB_ST_VALID;
        default: epb_next = `EPB_ST_FREE;
      endcase
    end
  endfunction

  // step arbitration across the two slots
  always @* begin : arb
    reg ev;
    reg claim;
    reg ok_a;
    reg ok_b;
    ev = 1'b0;
    claim = 1'b0;
    ok_a = 1'b0;
    ok_b = 1'b0;
    step_a = 1'b0;
    step_b = 1'b0;
    ev = EV_CLAIM | EV_RELEASE;
    claim = EV_CLAIM;
    // a slot may step when the event fits and its target is not held
    // no shared state
    ok_a = epb_movable(st_a, dir_in, claim) &&
           (!dbl || epb_next(st_a, dir_in) != st_b);
    ok_b = dbl && epb_movable(st_b, dir_in, claim) &&
           (epb_next(st_b, dir_in) != st_a);
    if (ev && !clear) begin
      // the slot whose turn it is goes first, the other fills in
      if (!turn) begin
        step_a = ok_a;
        step_b = ~ok_a & ok_b;
      end else begin
        step_b = ok_b;
        step_a = ~ok_b & ok_a;
      end
    end
  end

  // slot a
  epb_buffer_slot u_slot_a (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .CE(CE),
    .dir_in(dir_in),
    .clear(clear),
    .step(step_a),
    .state(st_a)
  );

  // slot b
  epb_buffer_slot u_slot_b (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .CE(CE),
    .dir_in(dir_in),
    .clear(clear | ~dbl),
    .step(step_b),
    .state(st_b)
  );

  assign report = {4'h0, st_b, st_a};

  // turn pointer: in double buffered mode, flips whenever the slot whose turn it is takes a step
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      turn <= 1'b0;
    end else if (CE) begin
      if (clear || !dbl) begin
        turn <= 1'b0;
      end else if ((step_a && !turn) || (step_b && turn)) begin
        // the leading slot moved; next event favours the other one
        turn <= ~turn;
      end
    end
  end

  // configuration register and clear pulse
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cfg <= `EPB_CFG_RESET;
      clear <= 1'b0;
    end else if (CE) begin
      clear <= 1'b0;
      if (wr && PADDR == `EPB_ADDR_CFG) begin
        // changing mode restarts both slots from free
        cfg <= PWDATA[1:0];
        clear <= 1'b1;
      end
    end
  end

  // apb answer: one wait state per access, ready for one cycle
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= acc;
      PSLVERR <= 1'b0;
      if (rd) begin
        case (PADDR)
          `EPB_ADDR_STATES: PRDATA <= {24'h000000, report};
          `EPB_ADDR_CFG: PRDATA <= {30'h00000000, cfg};
          default: PRDATA <= 32'h00000000;
        endcase
      end
      if (acc) begin
        if (PADDR != `EPB_ADDR_STATES && PADDR != `EPB_ADDR_CFG) begin
          // unmapped address flags an error
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  // registered copy of the report
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      STATE_REPORT <= 8'h00;
    end else if (CE) begin
      STATE_REPORT <= report;
    end
  end

endmodule
`default_nettype wire

// ---- verif/epb_chk.sv ----
/* port assertions for the buffer tracker; assumes apb from one master and that CE low freezes the design */
`timescale 1ns/10ps
`default_nettype none
`include "epb_consts.vh"
module epb_chk (
  // clock and apb
  input wire logic CLK_SYS, NRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  // events and status
  input wire logic EV_CLAIM, EV_RELEASE,
  input wire logic [7:0] STATE_REPORT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // slot fields
  wire [1:0] a = STATE_REPORT[1:0];
  wire [1:0] b = STATE_REPORT[3:2];
  // first access cycle of a transfer
  sequence s_acc; PSEL && PENABLE && !PREADY && CE; endsequence
  // no event and no configuration write
  sequence s_quiet; !EV_CLAIM && !EV_RELEASE && !(PSEL && PWRITE && PADDR == `EPB_ADDR_CFG); endsequence
  AST_SLOTS_APART: assert property (a == b |-> a == `EPB_ST_FREE) else $error("slots share a state");
  AST_UPPER_ZERO: assert property (STATE_REPORT[7:4] == 4'h0) else $error("upper bits set");
  AST_A_NO_SKIP: assert property ($past(a) == `EPB_ST_FREE |-> a != `EPB_ST_VALID) else $error("a skipped");
  AST_B_NO_SKIP: assert property ($past(b) == `EPB_ST_FREE |-> b != `EPB_ST_VALID) else $error("b skipped");
  AST_READY_LAT: assert property (s_acc |=> PREADY) else $error("no answer");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held");
  AST_ERR_MAP: assert property (PREADY |-> PSLVERR == !(PADDR == `EPB_ADDR_STATES || PADDR == `EPB_ADDR_CFG))
    else $error("bad error flag");
  AST_RD_STATE: assert property (PREADY && !PWRITE && PADDR == `EPB_ADDR_STATES |-> PRDATA[31:8] == 24'h0 &&
    (PRDATA[7:0] == STATE_REPORT || PRDATA[7:0] == $past(STATE_REPORT))) else $error("bad state read");
  AST_WR_IGNORED: assert property (s_quiet [*3] |=> $stable(STATE_REPORT)) else $error("state moved");
endmodule
bind epb_endpoint_buffers epb_chk i_epb_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR), .PRDATA(PRDATA),
  .EV_CLAIM(EV_CLAIM), .EV_RELEASE(EV_RELEASE), .STATE_REPORT(STATE_REPORT));
`default_nettype wire

// ---- verif/epb_cpu_model.sv ----
/* local processor model: apb master; assumes a slave that answers with PREADY */
`timescale 1ns/10ps
`default_nettype none
module epb_cpu_model (
  // answer
  input wire logic CLK_SYS, PREADY, PSLVERR,
  input wire logic [31:0] PRDATA,
  // request
  output logic PSEL, PENABLE, PWRITE,
  output logic [11:0] PADDR,
  output logic [31:0] PWDATA
);
  initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
  // one transfer: setup, access held until ready is sampled
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/epb_endpoint_buffers_tb.sv ----
/* self-checking bench for the buffer tracker; assumes the checker is bound in */
`timescale 1ns/10ps
`default_nettype none
`include "epb_consts.vh"
module epb_endpoint_buffers_tb;
  logic CLK_SYS = 1'b0, NRST = 1'b0, CE = 1'b1, EV_CLAIM = 1'b0, EV_RELEASE = 1'b0;
  wire PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  wire [11:0] PADDR;
  wire [31:0] PWDATA, PRDATA;
  wire [7:0] STATE_REPORT;
  int fails = 0, samples_checked = 0;
  logic [31:0] rd;
  logic err;
  always #10 CLK_SYS = ~CLK_SYS;
  epb_endpoint_buffers i_epb_endpoint_buffers (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EV_CLAIM(EV_CLAIM), .EV_RELEASE(EV_RELEASE), .STATE_REPORT(STATE_REPORT));
  epb_cpu_model i_epb_cpu_model (.CLK_SYS(CLK_SYS), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));
  task check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one-cycle event pulse from the protocol side
  task ev(input logic c, r);
    @(posedge CLK_SYS);
    EV_CLAIM <= c;
    EV_RELEASE <= r;
    @(posedge CLK_SYS);
    EV_CLAIM <= 1'b0;
    EV_RELEASE <= 1'b0;
  endtask
  task rd_state(input logic [7:0] exp);
    i_epb_cpu_model.xfer(1'b0, `EPB_ADDR_STATES, 32'h0, rd, err);
    check("state word", rd, {24'h0, exp});
    check("state port", STATE_REPORT, exp);
  endtask
  task t_reset;
    rd_state(8'h00);
    i_epb_cpu_model.xfer(1'b0, 12'h040, 32'h0, rd, err);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("reset and map test done");
  endtask
  // claim, claim, release, release, claim, release through one slot; the repeated events must not move it
  task walk_single(input logic [1:0] cfg, input logic [7:0] s0, s2);
    i_epb_cpu_model.xfer(1'b1, `EPB_ADDR_CFG, {30'h0, cfg}, rd, err);
    ev(1'b1, 1'b0);
    rd_state(s0);
    ev(1'b1, 1'b0);
    rd_state(s0);
    ev(1'b0, 1'b1);
    rd_state(8'h01);
    ev(1'b0, 1'b1);
    i_epb_cpu_model.xfer(1'b1, `EPB_ADDR_STATES, 32'hFFFFFFFF, rd, err);
    check("state write error", err, 1'b0);
    rd_state(8'h01);
    ev(1'b1, 1'b0);
    rd_state(s2);
    ev(1'b0, 1'b1);
    rd_state(8'h00);
    $display("single walk done");
  endtask
  // enable low freezes the slots; a reset in mid-run returns all to free and single out mode
  task t_freeze_reset;
    @(posedge CLK_SYS);
    CE <= 1'b0;
    ev(1'b1, 1'b0);
    repeat (2) @(posedge CLK_SYS);
    check("frozen state", STATE_REPORT, 8'h00);
    CE <= 1'b1;
    ev(1'b1, 1'b0);
    rd_state(8'h02);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    check("reset state", STATE_REPORT, 8'h00);
    NRST <= 1'b1;
    rd_state(8'h00);
    i_epb_cpu_model.xfer(1'b0, `EPB_ADDR_CFG, 32'h0, rd, err);
    check("reset config", rd, 32'h0);
    $display("freeze and reset done");
  endtask
  task walk_double;
    i_epb_cpu_model.xfer(1'b1, `EPB_ADDR_CFG, 32'h3, rd, err);
    ev(1'b1, 1'b0);
    rd_state(8'h02);
    for (int i = 0; i < 12; i++) begin
      ev(i % 3 != 2, i % 3 == 2);
      repeat (2) @(posedge CLK_SYS);
      check("slots apart", STATE_REPORT[1:0] != STATE_REPORT[3:2] || STATE_REPORT[3:0] == 4'h0, 1'b1);
    end
    $display("double walk done");
  endtask
  initial begin
    repeat (16) @(posedge CLK_SYS);
    NRST <= 1'b1;
    t_reset;
    walk_single(2'h0, 8'h03, 8'h02);
    walk_single(2'h1, 8'h02, 8'h03);
    t_freeze_reset;
    walk_double;
    tally_and_finish;
  end
  // watchdog against a hung transfer
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
